// >>> rtl/rpw_reset_wakeup.v
/*
 * rpw_reset_wakeup.v: reset pin, reset pulse, idle/powerdown exit and
 * clock doubler enable for a 16-bit microcontroller core.
 * assumes: one 25 MHz clock; reset pin and doubler enable come from the
 * board and are synchronised here; mode requests come from the core.
 */
// Overview of operation
// - a low sampled level on the reset pin holds the whole chip in reset.
// - the reset pin is open drain, only ever pulled low, never driven high.
// - a pin falling edge or an internal reset pulls the pin low for 16 state times.
// - asserting the reset pin in idle or powerdown resets the chip and returns to normal.
// - after reset the first fetch is at ff2080, seen as 1f2080 on external memory.
// - on leaving powerdown by a wake event the core and peripheral clocks stay gated until the return delay ends.
// - the clock doubler is enabled only while its enable input is high.
`timescale 1ns/1ps
`include "rpw_defs.vh"

module rpw_reset_wakeup #(
    parameter STATE_DIV   = `RPW_STATE_DIV,
    parameter PULL_STATES = `RPW_PULL_STATES,
    parameter WAKE_STATES = `RPW_WAKE_STATES
) (
    input  wire        ref_clk_in,
    input  wire        rst_b_in,
    input  wire        reset_pin_in,
    output wire        reset_pin_out,
    output wire        reset_pin_oe_out,
    input  wire        internal_reset_in,
    input  wire        idle_req_in,
    input  wire        pdown_req_in,
    input  wire        wake_event_in,
    input  wire        clock_doubler_enable_in,
    input  wire        fetch_external_in,
    output reg         chip_reset_out,
    output reg         core_clk_en_out,
    output reg         periph_clk_en_out,
    output reg         clock_doubler_on_out,
    output reg  [1:0]  mode_out,
    output reg  [23:0] fetch_vector_out,
    output wire        state_tick_out
);

    localparam  SYNC_W   = 2;
    localparam  SYNC_PIN = 0;
    localparam  SYNC_DEN = 1;

    wire [1:0]  sync_d;
    wire [1:0]  sync_idle;
    reg  [1:0]  sync_s1_r;
    reg  [1:0]  sync_s2_r;
    wire        pin_sync;
    wire        den_sync;
    reg         pin_prev_r;
    reg  [15:0] div_r;
    reg  [15:0] pull_cnt_r;
    reg  [15:0] wake_cnt_r;
    reg  [1:0]  mode_r;
    reg  [1:0]  mode_nxt;
    wire        tick;
    wire        pin_fall;
    wire        pull_active;
    wire        pull_start;

    // one state time is STATE_DIV reference clocks
    assign tick           = (div_r == (STATE_DIV[15:0] - 16'h0001));
    assign state_tick_out = tick;
    assign sync_d         = {clock_doubler_enable_in, reset_pin_in};
    assign sync_idle      = {`RPW_DEN_IDLE, `RPW_PIN_IDLE};
    assign pin_sync       = sync_s2_r[SYNC_PIN];
    assign den_sync       = sync_s2_r[SYNC_DEN];
    assign pin_fall       = pin_prev_r & ~pin_sync;
    assign pull_active    = (pull_cnt_r != 16'h0000);
    // our own pull-down drags the pad low and comes back as a pin fall a few clocks
    // later; ignoring falls while pulling keeps the pulse at 16 state times
    assign pull_start     = (pin_fall && !pull_active) || internal_reset_in;

    // only ever a low driver; the pad pull-up owns the high level
    assign reset_pin_out    = 1'b0;
    assign reset_pin_oe_out = pull_active;

    // mode decode shared by the clock gates and the wake counter
    function mode_is;
        input [1:0] cur;
        input [1:0] want;
        begin
            mode_is = (cur == want);
        end
    endfunction

    // one state time off a running count, held at zero once it gets there
    function [15:0] count_down;
        input [15:0] cnt;
        input        en;
        begin
            if (en && cnt != 16'h0000) begin
                count_down = cnt - 16'h0001;
            end else begin
                count_down = cnt;
            end
        end
    endfunction

    // two-stage synchronisers; nothing but the second stage reads the first
    genvar g;
    generate
        for (g = 0; g < SYNC_W; g = g + 1) begin : g_sync
            always @(posedge ref_clk_in) begin
                if (!rst_b_in) begin
                    sync_s1_r[g] <= sync_idle[g];
                    sync_s2_r[g] <= sync_idle[g];
                end else begin
                    sync_s1_r[g] <= sync_d[g];
                    sync_s2_r[g] <= sync_s1_r[g];
                end
            end
        end
    endgenerate

    // previous synced pin level for the falling-edge detector
    always @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            pin_prev_r <= `RPW_PIN_IDLE;
        end else begin
            pin_prev_r <= pin_sync;
        end
    end

    // state-time enable divider
    always @(posedge ref_clk_in) begin
        if (!rst_b_in || tick) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_r + 16'h0001;
        end
    end

    // pull-down pulse; a new trigger restarts the full count
    always @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            pull_cnt_r <= 16'h0000;
        end else if (pull_start) begin
            pull_cnt_r <= PULL_STATES[15:0];
        end else begin
            pull_cnt_r <= count_down(pull_cnt_r, tick);
        end
    end

    // mode machine
    // idle wakes straight to normal; powerdown first waits out the return delay
    always @* begin
        mode_nxt = mode_r;
        case (mode_r)
            `RPW_MODE_NORMAL: begin
                if (pdown_req_in) begin
                    mode_nxt = `RPW_MODE_PDOWN;
                end else if (idle_req_in) begin
                    mode_nxt = `RPW_MODE_IDLE;
                end
            end
            `RPW_MODE_IDLE: begin
                if (wake_event_in) begin
                    mode_nxt = `RPW_MODE_NORMAL;
                end
            end
            `RPW_MODE_PDOWN: begin
                if (wake_event_in) begin
                    mode_nxt = `RPW_MODE_WAKE;
                end
            end
            `RPW_MODE_WAKE: begin
                if (wake_cnt_r == 16'h0000) begin
                    mode_nxt = `RPW_MODE_NORMAL;
                end
            end
            default: mode_nxt = `RPW_MODE_NORMAL;
        endcase
    end

    // reset overrides idle or powerdown and lands in normal mode
    always @(posedge ref_clk_in) begin
        if (!rst_b_in || !pin_sync || pull_active) begin
            mode_r <= `RPW_MODE_NORMAL;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // return-from-powerdown delay, counted in state times; WAKE_STATES stands in
    // for the board's timing capacitor and must cover oscillator and doubler settling
    always @(posedge ref_clk_in) begin
        if (!rst_b_in || !mode_is(mode_r, `RPW_MODE_WAKE)) begin
            wake_cnt_r <= WAKE_STATES[15:0];
        end else begin
            wake_cnt_r <= count_down(wake_cnt_r, tick);
        end
    end

    // registered outputs
    always @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            chip_reset_out       <= 1'b1;
            core_clk_en_out      <= 1'b0;
            periph_clk_en_out    <= 1'b0;
            clock_doubler_on_out <= 1'b0;
            mode_out             <= `RPW_MODE_NORMAL;
            fetch_vector_out     <= `RPW_RESET_VECTOR;
        end else begin
            // chip reset stays up until both the synced pin and the pull pulse let go
            chip_reset_out       <= !pin_sync || pull_active;
            // doubler keeps running through the wake delay so it can settle
            clock_doubler_on_out <= den_sync;
            core_clk_en_out      <= mode_is(mode_r, `RPW_MODE_NORMAL);
            periph_clk_en_out    <= mode_is(mode_r, `RPW_MODE_NORMAL) ||
                                    mode_is(mode_r, `RPW_MODE_IDLE);
            mode_out             <= mode_r;
            fetch_vector_out     <= fetch_external_in ? `RPW_RESET_VECTOR_EXT
                                                      : `RPW_RESET_VECTOR;
        end
    end

endmodule

// >>> rtl/rpw_defs.vh
/*
 * rpw_defs.vh: constants for the reset pin and wake-up control block.
 * assumes: included by rtl/rpw_reset_wakeup.v and by the assertion and top-level testbench files.
 */
`ifndef RPW_DEFS_VH
`define RPW_DEFS_VH

// pull-down pulse length in state times
`define RPW_PULL_STATES      16
// reference clocks per state time (default divider)
`define RPW_STATE_DIV        2
// powerdown return delay in state times (default, stands for the capacitor delay)
`define RPW_WAKE_STATES      1024
// reset fetch vector, internal and external views
`define RPW_RESET_VECTOR     24'hff2080
`define RPW_RESET_VECTOR_EXT 24'h1f2080
// synchroniser levels while in reset: pin released high, doubler off
`define RPW_PIN_IDLE         1'b1
`define RPW_DEN_IDLE         1'b0
// operating modes
`define RPW_MODE_NORMAL      2'h0
`define RPW_MODE_IDLE        2'h1
`define RPW_MODE_PDOWN       2'h2
`define RPW_MODE_WAKE        2'h3

`endif

// >>> testbench/rpw_props.sv
/* rpw_props: assertions on the ports of rpw_reset_wakeup.
   assumes: bound from testbench, one clock domain. */
`timescale 1ns/1ps
`include "rpw_defs.vh"
module rpw_props (
    input wire        ref_clk_in,
    input wire        rst_b_in,
    input wire        reset_pin_in,
    input wire        reset_pin_out,
    input wire        reset_pin_oe_out,
    input wire        internal_reset_in,
    input wire        clock_doubler_enable_in,
    input wire        fetch_external_in,
    input wire        chip_reset_out,
    input wire        core_clk_en_out,
    input wire        periph_clk_en_out,
    input wire        clock_doubler_on_out,
    input wire [1:0]  mode_out,
    input wire [23:0] fetch_vector_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    // three samples: two sync stages, then the output register
    sequence s_pin_low; !reset_pin_in [*3]; endsequence
    sequence s_den_low; !clock_doubler_enable_in [*3]; endsequence
    a_open_drain: assert property (!reset_pin_out)
        else $error("pin driven high");
    a_pull_start: assert property (internal_reset_in |=> reset_pin_oe_out)
        else $error("no pull-down");
    a_pin_holds: assert property (s_pin_low |=> chip_reset_out)
        else $error("pin low, chip free");
    a_pull_holds: assert property (reset_pin_oe_out |=> chip_reset_out)
        else $error("pull on, chip free");
    // mode is forced on the same edge that samples the pull, and mode_out registers it one later
    a_reset_mode: assert property (reset_pin_oe_out |-> ##2 (mode_out == `RPW_MODE_NORMAL))
        else $error("mode kept in reset");
    a_vector_view: assert property ($past(rst_b_in) |-> fetch_vector_out ==
        ($past(fetch_external_in) ? `RPW_RESET_VECTOR_EXT : `RPW_RESET_VECTOR))
        else $error("bad vector");
    a_sleep_gate: assert property (mode_out[1] |-> !core_clk_en_out && !periph_clk_en_out)
        else $error("clock on in sleep");
    a_doubler_off: assert property (s_den_low |=> !clock_doubler_on_out)
        else $error("doubler on");
endmodule

// >>> testbench/rpw_board.sv
/* rpw_board: board reset circuit and doubler enable source.
   assumes: pull-up on the reset line. */
`timescale 1ns/1ps
module rpw_board (
    input  wire press_in,
    input  wire oe_in,
    input  wire data_in,
    input  wire emu_in,
    input  wire den_in,
    output wire pad_out,
    output wire den_out
);
    assign pad_out = !(press_in || (oe_in && !data_in)); // wired low, pull-up
    assign den_out = den_in && !emu_in; // low in emulation mode
endmodule

// >>> testbench/testbench.sv
/* testbench: drives rpw_reset_wakeup beside the board model.
   assumes: rtl include path set. */
`timescale 1ns/1ps
`include "rpw_defs.vh"
module testbench;
    reg         clk, rst_b, ires, idle, pdn, wake, den, ext, press, emu;
    wire        pad, den_w, pout, oe, crst, cen, pen, don, tick;
    wire [1:0]  mode;
    wire [23:0] vec;
    integer     n_errors = 0, cmp_count = 0, n, i, t_off;
    rpw_board brd_u (.press_in(press), .oe_in(oe), .data_in(pout), .emu_in(emu),
        .den_in(den), .pad_out(pad), .den_out(den_w));
    rpw_reset_wakeup #(.WAKE_STATES(4)) dut_u (.ref_clk_in(clk), .rst_b_in(rst_b),
        .reset_pin_in(pad), .reset_pin_out(pout), .reset_pin_oe_out(oe),
        .internal_reset_in(ires), .idle_req_in(idle), .pdown_req_in(pdn),
        .wake_event_in(wake), .clock_doubler_enable_in(den_w), .fetch_external_in(ext),
        .chip_reset_out(crst), .core_clk_en_out(cen), .periph_clk_en_out(pen),
        .clock_doubler_on_out(don), .mode_out(mode), .fetch_vector_out(vec),
        .state_tick_out(tick));
    task chk(input [23:0] seen, input [23:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task step(input integer k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // counts clocks until pull and chip reset are both gone
    // t_off: clocks until the pull lets go; n: clocks until chip reset lets go too
    task wt;
        n = 0;
        t_off = -1;
        while ((oe !== 1'b0 || crst !== 1'b0) && n < 99) begin
            step(1);
            n = n + 1;
            if (oe === 1'b0 && t_off < 0) t_off = n;
        end
    endtask
    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    initial begin
        #100000;
        n_errors = n_errors + 1;
        end_sim;
    end
    initial begin
        {rst_b, ires, idle, pdn, wake, den, ext, press, emu} = 9'h000;
        n = $urandom(32'h5f27);
        step(4);
        rst_b = 1;
        step(2);
        ires = 1;
        step(1);
        ires = 0;
        wt;
        chk(n >= 2 * 16 - 1 && n <= 2 * 16 + 3, 1);
        chk(t_off >= 2 * 16 - 1 && t_off <= 2 * 16, 1);
        chk(n - t_off, 3);
        step(1);
        chk(cen, 1);
        $display("pull pulse test done");
        t_off = 0;
        for (i = 0; i < 8; i = i + 1) begin
            step(1);
            t_off = t_off + tick;
        end
        chk(t_off, 8 / `RPW_STATE_DIV);
        $display("state tick test done");
        idle = 1;
        step(2);
        idle = 0;
        chk(mode, `RPW_MODE_IDLE);
        press = 1;
        step(4 + $urandom % 16);
        chk(crst, 1);
        press = 0;
        wt;
        chk(n - t_off, 3);
        step(1);
        chk({mode, cen}, {`RPW_MODE_NORMAL, 1'b1});
        $display("idle exit test done");
        pdn = 1;
        step(2);
        pdn = 0;
        chk({mode, cen, pen}, {`RPW_MODE_PDOWN, 2'b00});
        wake = 1;
        step(2);
        wake = 0;
        for (n = 0; mode === `RPW_MODE_WAKE && n < 99; n = n + 1) step(1);
        chk(n >= 4 * 2 - 2 && n <= 4 * 2 + 2, 1);
        step(1);
        chk(cen, 1);
        $display("powerdown test done");
        pdn = 1;
        step(2);
        pdn = 0;
        chk(mode, `RPW_MODE_PDOWN);
        ires = 1;
        step(1);
        ires = 0;
        wt;
        chk(n - t_off, 3);
        step(1);
        chk({mode, cen, pen}, {`RPW_MODE_NORMAL, 2'b11});
        $display("powerdown reset test done");
        for (i = 0; i < 8; i = i + 1) begin
            n = $urandom;
            {ext, den, emu} = n[2:0];
            step(4);
            chk(vec, ext ? `RPW_RESET_VECTOR_EXT : `RPW_RESET_VECTOR);
            chk(don, den && !emu);
        end
        $display("vector and doubler test done");
        end_sim;
    end
endmodule
bind rpw_reset_wakeup rpw_props props_u (.ref_clk_in, .rst_b_in, .reset_pin_in,
    .reset_pin_out, .reset_pin_oe_out, .internal_reset_in, .clock_doubler_enable_in,
    .fetch_external_in, .chip_reset_out, .core_clk_en_out, .periph_clk_en_out,
    .clock_doubler_on_out, .mode_out, .fetch_vector_out);
